//--- pkg/mvidl_defines.svh
// Encoding constants, field positions, reset values and timing counts for the move and idle decoder.
`ifndef MVIDL_DEFINES_SVH
`define MVIDL_DEFINES_SVH
`define MVIDL_OP_W 14
`define MVIDL_ADDR_W 7
`define MVIDL_DATA_W 8
`define MVIDL_DEST_BIT 7
`define MVIDL_MOVE_MASK 14'h3F00
`define MVIDL_MOVE_CODE 14'h0800
`define MVIDL_STORE_MASK 14'h3F80
`define MVIDL_STORE_CODE 14'h0080
`define MVIDL_IDLE_MASK 14'h3F9F
`define MVIDL_IDLE_CODE 14'h0000
`define MVIDL_PHASES 4
`define MVIDL_PHASE_RST 2'h0
`define MVIDL_PHASE_LAST 2'h3
`define MVIDL_W_RST 8'h00
`define MVIDL_Z_RST 1'b0
`define MVIDL_ADDR_RST 7'h00
`define MVIDL_WDATA_RST 8'h00
`endif

//--- pkg/mvidl_pkg.sv
// Types shared by the move and idle decoder files.
package mvidl_pkg;
  typedef enum logic [1:0] {MVIDL_OP_IDLE, MVIDL_OP_MOVE, MVIDL_OP_STORE, MVIDL_OP_OTHER} mvidl_op_t;
endpackage : mvidl_pkg

//--- src/mvidl_decode.sv
// Combinational opcode classifier for the move and idle decoder.
`timescale 1ns/1ns
`include "mvidl_defines.svh"
module mvidl_decode
(
  input wire logic [13:0] opcode, // Instruction word from program memory.
  output mvidl_pkg::mvidl_op_t op_kind // Decoded instruction class.
);
  import mvidl_pkg::*;

  // Classify by masked compare; the idle mask drops its two don't-care bits.
  always_comb
  begin
    if ((opcode & `MVIDL_MOVE_MASK) == `MVIDL_MOVE_CODE)
      op_kind = MVIDL_OP_MOVE;
    else if ((opcode & `MVIDL_STORE_MASK) == `MVIDL_STORE_CODE)
      op_kind = MVIDL_OP_STORE;
    else if ((opcode & `MVIDL_IDLE_MASK) == `MVIDL_IDLE_CODE)
      op_kind = MVIDL_OP_IDLE;
    else
      op_kind = MVIDL_OP_OTHER;
  end
endmodule : mvidl_decode

//--- src/mvidl_exec.sv
// Execute unit for the file move, working store and idle instructions.
// Functional notes
// - File move reads f, routes by destination bit.
// - Destination one writes f, zero writes working.
// - File move sets zero flag from moved value.
// - Store copies working into f, flags untouched.
// - One instruction cycle equals four clock phases.
// - Extra skip or jump cycle runs as idle.
`timescale 1ns/1ns
`include "mvidl_defines.svh"
module mvidl_exec
(
  input wire logic clk, // Core clock, one oscillator period per edge.
  input wire logic sys_rst, // Synchronous active high reset.
  input wire logic [13:0] opcode, // Instruction word, held stable through the cycle.
  input wire logic flush, // High when this cycle is a skip or jump filler.
  input wire logic [7:0] file_rdata, // Read data of the addressed file register.
  output logic [6:0] file_addr, // File register address.
  output logic [7:0] file_wdata, // File register write data.
  output logic file_we, // One-phase file register write strobe.
  output logic [7:0] w_out, // Working register value.
  output logic z_flag, // Zero flag.
  output logic pc_inc, // One-phase program counter advance pulse.
  output logic cycle_start // High in the first phase of each instruction cycle but the first after reset.
);
  import mvidl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Decode.

  mvidl_op_t op_kind; // Class of the current instruction.

  // The classifier is split out so a wider core can reuse it.
  mvidl_decode u_decode
  (
    .opcode(opcode),
    .op_kind(op_kind)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Phase counter and registered state.

  logic [1:0] phase_reg; // Current oscillator phase within the cycle.
  logic [1:0] phase_next; // Next phase.
  logic [7:0] w_reg; // Working register.
  logic [7:0] w_next; // Next working register.
  logic z_reg; // Zero flag.
  logic z_next; // Next zero flag.
  logic [6:0] addr_reg; // Registered file address.
  logic [6:0] addr_next; // Next file address.
  logic [7:0] wdata_reg; // Registered write data.
  logic [7:0] wdata_next; // Next write data.
  logic we_reg; // Registered write strobe.
  logic we_next; // Next write strobe.
  logic pc_reg; // Registered counter advance.
  logic pc_next; // Next counter advance.
  logic start_reg; // Registered cycle start.
  logic start_next; // Next cycle start.
  logic dest_file; // Destination select bit of a file move.

  assign dest_file = opcode[`MVIDL_DEST_BIT];

  // Next-state logic. Reads settle in the early phases; all commits happen in
  // the last phase so every instruction spends exactly four edges.
  always_comb
  begin
    phase_next = phase_reg + 2'd1;
    w_next = w_reg;
    z_next = z_reg;
    addr_next = opcode[6:0];
    wdata_next = wdata_reg;
    we_next = 1'b0;
    pc_next = 1'b0;
    start_next = (phase_reg == `MVIDL_PHASE_LAST);
    if (phase_reg == `MVIDL_PHASE_LAST)
    begin
      // The counter advances on every cycle, idle and filler included.
      pc_next = 1'b1;
      if (flush)
      begin
        // A filler cycle commits nothing, whatever the fetched word is.
        we_next = 1'b0;
      end
      else
      begin
        // The class, and for a move the destination bit, picks what is committed in the last phase.
        case (op_kind)
          MVIDL_OP_MOVE:
          begin
            // The flag follows the moved value for either destination.
            z_next = (file_rdata == 8'h00);
            if (dest_file)
            begin
              wdata_next = file_rdata;
              we_next = 1'b1;
            end
            else
            begin
              w_next = file_rdata;
            end
          end
          MVIDL_OP_STORE:
          begin
            // The flag is left alone on purpose, so a store never disturbs a test result.
            wdata_next = w_reg;
            we_next = 1'b1;
          end
          MVIDL_OP_IDLE:
          begin
            we_next = 1'b0;
          end
          default:
          begin
            // Other instructions belong to other execute units.
            we_next = 1'b0;
          end
        endcase
      end
    end
  end

  // Register stage only.
  // Reset is synchronous, so a reset pulse that misses every edge is lost.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase_reg <= `MVIDL_PHASE_RST;
      w_reg <= `MVIDL_W_RST;
      z_reg <= `MVIDL_Z_RST;
      addr_reg <= `MVIDL_ADDR_RST;
      wdata_reg <= `MVIDL_WDATA_RST;
      we_reg <= 1'b0;
      pc_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      w_reg <= w_next;
      z_reg <= z_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      we_reg <= we_next;
      pc_reg <= pc_next;
      start_reg <= start_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the registers, so the register file and the
  // counter see no combinational path back from their own inputs.

  assign file_addr = addr_reg;
  assign file_wdata = wdata_reg;
  assign file_we = we_reg;
  assign w_out = w_reg;
  assign z_flag = z_reg;
  assign pc_inc = pc_reg;
  assign cycle_start = start_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // The flag after a move reflects the value that was read, whatever the destination.
  a_move_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (phase_reg == 2'h3 && !flush && op_kind == MVIDL_OP_MOVE) |=> (z_reg == ($past(file_rdata) == 8'h00)))
    else $error("zero flag not taken from moved value");

  // A move toward the working register loads it and leaves the register file alone.
  a_move_to_w: assert property (@(posedge clk) disable iff (sys_rst)
    (phase_reg == 2'h3 && !flush && op_kind == MVIDL_OP_MOVE && !dest_file)
    |=> (w_reg == $past(file_rdata) && !we_reg))
    else $error("file move to working register failed");

  // A move back onto the file register writes the value read and keeps the working register.
  a_move_to_file: assert property (@(posedge clk) disable iff (sys_rst)
    (phase_reg == 2'h3 && !flush && op_kind == MVIDL_OP_MOVE && dest_file)
    |=> (we_reg && wdata_reg == $past(file_rdata) && $stable(w_reg)))
    else $error("file move write back failed");

  // A store writes the working register and keeps the flag.
  a_store_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (phase_reg == 2'h3 && !flush && op_kind == MVIDL_OP_STORE)
    |=> (we_reg && wdata_reg == $past(w_reg) && $stable(z_reg)))
    else $error("store changed flags or data wrong");

  // An idle word only advances the counter.
  a_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (phase_reg == 2'h3 && op_kind == MVIDL_OP_IDLE) |=> (!we_reg && pc_reg && $stable(w_reg) && $stable(z_reg)))
    else $error("idle instruction changed state");

  // Advance pulses are exactly four edges apart.
  a_cycle_four: assert property (@(posedge clk) disable iff (sys_rst)
    pc_reg |=> !pc_reg[*3] ##1 pc_reg)
    else $error("instruction cycle not four phases");

  // A filler cycle behaves as an idle word whatever opcode it carries.
  a_flush_idle: assert property (@(posedge clk) disable iff (sys_rst)
    (phase_reg == 2'h3 && flush) |=> (!we_reg && $stable(w_reg) && $stable(z_reg) && pc_reg))
    else $error("filler cycle was not idle");

  // At most one write per instruction cycle.
  a_we_single: assert property (@(posedge clk) disable iff (sys_rst)
    we_reg |=> !we_reg ##1 !we_reg ##1 !we_reg)
    else $error("write strobe repeated within a cycle");

  // The register file sees the opcode's address field one edge late.
  a_addr_follow: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst |=> (file_addr == $past(opcode[6:0])))
    else $error("file address does not follow opcode");

  // Only a committed move toward the working register may change it.
  a_w_source: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(w_reg) |-> ($past(phase_reg) == 2'h3 && $past(op_kind) == MVIDL_OP_MOVE
    && !$past(flush) && !$past(dest_file)))
    else $error("working register changed outside a move");

  // Only a committed move may change the flag; store, idle and filler keep it.
  a_z_source: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(z_reg) |-> ($past(phase_reg) == 2'h3 && $past(op_kind) == MVIDL_OP_MOVE && !$past(flush)))
    else $error("zero flag changed outside a move");

  // The advance pulse only follows the last phase and marks a new cycle.
  a_pc_phase: assert property (@(posedge clk) disable iff (sys_rst)
    pc_reg |-> ($past(phase_reg) == 2'h3 && cycle_start))
    else $error("counter advance outside the last phase");
endmodule : mvidl_exec

//--- verif/mvidl_regfile.sv
// Behavioural file register space that answers the execute unit.
`timescale 1ns/1ns
module mvidl_regfile (
  input wire logic clk, // Core clock.
  input wire logic [6:0] file_addr, // Register address.
  input wire logic [7:0] file_wdata, // Write data.
  input wire logic file_we, // Write strobe.
  output logic [7:0] file_rdata // Read data.
);
  logic [7:0] mem [0:127]; // Register storage.
  // Preload each register with its address folded against a pattern, so exactly one holds zero.
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i) ^ 8'h45;
  end
  // Reads are combinational, because the unit samples data in the cycle after it sets the address.
  assign file_rdata = mem[file_addr];
  // Writes land on the edge that sees the strobe.
  always @(posedge clk)
  begin
    if (file_we)
      mem[file_addr] <= file_wdata;
  end
endmodule : mvidl_regfile

//--- verif/tb_mvidl_exec.sv
// Self-checking bench for the move, store and idle execute unit.
`timescale 1ns/1ns
`include "mvidl_defines.svh"
module tb_mvidl_exec;
  logic clk = 1'b0; // Core clock.
  logic sys_rst = 1'b1; // Reset, held at start.
  logic [13:0] opcode = `MVIDL_IDLE_CODE; // Instruction word.
  logic flush = 1'b0; // Filler cycle flag.
  logic [7:0] file_rdata; // Read data from the model.
  logic [6:0] file_addr; // Address to the model.
  logic [7:0] file_wdata; // Write data to the model.
  logic file_we; // Write strobe.
  logic [7:0] w_out; // Working register.
  logic z_flag; // Zero flag.
  logic pc_inc; // Advance pulse.
  logic cycle_start; // Cycle start pulse.
  int bad_count = 0; // Mismatches seen.
  int n_checks = 0; // Comparisons made.
  always #50 clk = ~clk; // 100 ns period.
  mvidl_exec uut (.clk, .sys_rst, .opcode, .flush, .file_rdata, .file_addr, .file_wdata, .file_we,
    .w_out, .z_flag, .pc_inc, .cycle_start);
  mvidl_regfile far (.clk, .file_addr, .file_wdata, .file_we, .file_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Present one instruction and wait, bounded, for its commit pulse; a hang ends the run.
  task automatic run(input logic [13:0] op, input logic fl);
    int i;
    @(posedge clk);
    opcode <= op;
    flush <= fl;
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      #1;
      if (pc_inc === 1'b1)
        break;
    end
    if (i == 8)
    begin
      bad_count++;
      conclude();
    end
  endtask : run
  // Check the flag and the strobe together, since most scenarios need both.
  task automatic chk_zw(input logic z, input logic we);
    chk({7'h00, z_flag}, {7'h00, z});
    chk({7'h00, file_we}, {7'h00, we});
  endtask : chk_zw
  // Reset leaves the working register, the flag and both pulses low.
  task automatic sc_reset_state;
    chk(w_out, `MVIDL_W_RST);
    chk({7'h00, z_flag}, {7'h00, `MVIDL_Z_RST});
    chk({6'h00, file_we, pc_inc}, 8'h00);
  endtask : sc_reset_state
  // A non-zero value moved into the working register clears the flag and writes nothing.
  task automatic sc_move_to_working;
    run(`MVIDL_MOVE_CODE | 14'h0025, 1'b0);
    chk(w_out, 8'h60);
    chk_zw(1'b0, 1'b0);
  endtask : sc_move_to_working
  // Moving a zero register onto itself sets the flag and leaves the working register alone.
  task automatic sc_move_to_file;
    run(`MVIDL_MOVE_CODE | 14'h00C5, 1'b0);
    chk_zw(1'b1, 1'b1);
    chk(file_wdata, 8'h00);
    chk({1'b0, file_addr}, 8'h45);
    chk(w_out, 8'h60);
  endtask : sc_move_to_file
  // Store to the top address; the flag must keep its set state.
  task automatic sc_store_top;
    run(`MVIDL_STORE_CODE | 14'h007F, 1'b0);
    chk_zw(1'b1, 1'b1);
    chk(file_wdata, 8'h60);
    chk({1'b0, file_addr}, 8'h7F);
  endtask : sc_store_top
  // A filler cycle carrying a store opcode must not write.
  task automatic sc_filler_store;
    run(`MVIDL_STORE_CODE | 14'h0010, 1'b1);
    chk_zw(1'b1, 1'b0);
    chk(w_out, 8'h60);
  endtask : sc_filler_store
  // Every don't-care combination of the idle word leaves all state as it was.
  task automatic sc_idle_variants;
    for (int k = 0; k < 4; k++)
    begin
      run(`MVIDL_IDLE_CODE | 14'(k << 5), 1'b0);
      chk_zw(1'b1, 1'b0);
      chk(w_out, 8'h60);
    end
  endtask : sc_idle_variants
  // Back to back commits are four edges apart, and the advance pulse stands one edge only.
  task automatic sc_back_to_back;
    int n;
    for (n = 1; n < 9; n++)
    begin
      @(posedge clk);
      #1;
      if (pc_inc === 1'b1)
        break;
    end
    if (n == 9)
    begin
      bad_count++;
      conclude();
    end
    else
    begin
      chk(8'(n), 8'h04);
      chk({7'h00, cycle_start}, 8'h01);
      @(posedge clk);
      #1;
      chk({6'h00, pc_inc, cycle_start}, 8'h00);
    end
  endtask : sc_back_to_back
  // Words outside the three classes, near misses of the move and idle patterns included, change nothing.
  task automatic sc_other_opcodes;
    run(14'h0900, 1'b0);
    chk(w_out, 8'h60);
    chk_zw(1'b1, 1'b0);
    run(14'h0064, 1'b0);
    chk(w_out, 8'h60);
    chk_zw(1'b1, 1'b0);
    run(14'h3FFF, 1'b0);
    chk(w_out, 8'h60);
    chk_zw(1'b1, 1'b0);
  endtask : sc_other_opcodes
  // Read back: the filler left its target untouched and the store reached the top register.
  task automatic sc_readback;
    run(`MVIDL_MOVE_CODE | 14'h0010, 1'b0);
    chk(w_out, 8'h55);
    run(`MVIDL_MOVE_CODE | 14'h007F, 1'b0);
    chk(w_out, 8'h60);
    chk_zw(1'b0, 1'b0);
  endtask : sc_readback
  // A reset in mid-run clears the flag and the working register; the next cycle then runs normally.
  task automatic sc_mid_reset;
    run(`MVIDL_MOVE_CODE | 14'h00C5, 1'b0);
    chk_zw(1'b1, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(w_out, `MVIDL_W_RST);
    chk({6'h00, z_flag, file_we}, 8'h00);
    chk({6'h00, pc_inc, cycle_start}, 8'h00);
    @(posedge clk);
    sys_rst <= 1'b0;
    run(`MVIDL_MOVE_CODE | 14'h0025, 1'b0);
    chk(w_out, 8'h60);
    chk_zw(1'b0, 1'b0);
  endtask : sc_mid_reset
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    sc_reset_state();
    sc_move_to_working();
    sc_move_to_file();
    sc_store_top();
    sc_filler_store();
    sc_idle_variants();
    sc_back_to_back();
    sc_other_opcodes();
    sc_readback();
    sc_mid_reset();
    conclude();
  end
endmodule : tb_mvidl_exec
